/* logic/ssef_map.vh */
// Register map, field positions, reset values and encodings of the socket
// event flag and state block. Assumes byte addresses on a 32-bit AXI4-Lite bus.
`ifndef SSEF_MAP_VH
`define SSEF_MAP_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SSEF_ADDR_W          12
`define SSEF_OFS_COMMAND     12'h200
`define SSEF_OFS_EVENT_MASK  12'h204
`define SSEF_OFS_STATE       12'h208
`define SSEF_OFS_EVENT_FLAGS 12'h20c
`define SSEF_OFS_PROTOCOL    12'h210
`define SSEF_OFS_SUMMARY     12'h214

// ----------------------------------------------------------------------------
// Event flag bit positions
// ----------------------------------------------------------------------------
`define SSEF_BIT_SESSION_OPTION 7
`define SSEF_BIT_SESSION_FAIL   6
`define SSEF_BIT_SESSION_NEXT   5
`define SSEF_BIT_SEND_DONE      4
`define SSEF_BIT_TIMEOUT        3
`define SSEF_BIT_RX             2
`define SSEF_BIT_PEER_PEER_DISCONNECT_FLAG    1
`define SSEF_BIT_CONNECTED      0

// Summary register: bit 0 summary (read only), bit 1 global mask
`define SSEF_BIT_SUMMARY     0
`define SSEF_BIT_GLOBAL_MASK 1

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SSEF_RST_EVENT_MASK  8'hff
`define SSEF_RST_EVENT_FLAGS 8'h00
`define SSEF_RST_STATE       8'h00
`define SSEF_RST_PROTOCOL    4'h0
`define SSEF_RST_GLOBAL_MASK 1'b0

// ----------------------------------------------------------------------------
// Socket state codes
// ----------------------------------------------------------------------------
`define SSEF_ST_RELEASED     8'h00
`define SSEF_ST_INITIALISED  8'h13
`define SSEF_ST_LISTENING    8'h14
`define SSEF_ST_CONNECTED    8'h17
`define SSEF_ST_HALF_CLOSED  8'h1c
`define SSEF_ST_DATAGRAM     8'h22
`define SSEF_ST_RAW_NETWORK  8'h32
`define SSEF_ST_RAW_LINK     8'h42
`define SSEF_ST_SESSION_TUN  8'h5f

// ----------------------------------------------------------------------------
// Command codes and protocol field values
// ----------------------------------------------------------------------------
`define SSEF_CMD_OPEN    8'h01
`define SSEF_CMD_LISTEN  8'h02
`define SSEF_CMD_CONNECT 8'h04
`define SSEF_CMD_PEER_DISCONNECT_FLAG  8'h08
`define SSEF_CMD_CLOSE   8'h10
`define SSEF_CMD_SEND    8'h20
`define SSEF_CMD_RX_FLAG    8'h40

`define SSEF_PROTO_TCP     4'h1
`define SSEF_PROTO_UDP     4'h2
`define SSEF_PROTO_IPRAW   4'h3
`define SSEF_PROTO_MACRAW  4'h4
`define SSEF_PROTO_SESSION 4'h5

// AXI responses
`define SSEF_RESP_OKAY   2'h0
`define SSEF_RESP_SLVERR 2'h2

`endif

/* logic/ssef_socket_flags.v */
// One socket's event flags, event mask, state code and summary bit,
// reached over AXI4-Lite. Assumes protocol engines pulse the event inputs
// for one cycle and act on the request pulses this block gives out.
`include "ssef_map.vh"

module ssef_socket_flags #(
  parameter SOCKET_INDEX = 0
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        ev_session_option,
  input  wire        ev_session_fail,
  input  wire        ev_session_next,
  input  wire        ev_send_done,
  input  wire        ev_arp_timeout,
  input  wire        ev_tcp_timeout,
  input  wire        ev_rx_packet,
  input  wire        ev_peer_fin,
  input  wire        ev_connected,
  output reg         send_req,
  output reg         rx_flag_req,
  output reg         connect_req,
  output reg         disconnect_req,
  output reg         irq_n
);

  // --------------------------------------------------------------------------
  // Address decode and state selection
  // --------------------------------------------------------------------------
  localparam [2:0] REG_NONE     = 3'h0;
  localparam [2:0] REG_COMMAND  = 3'h1;
  localparam [2:0] REG_MASK     = 3'h2;
  localparam [2:0] REG_STATE    = 3'h3;
  localparam [2:0] REG_FLAGS    = 3'h4;
  localparam [2:0] REG_PROTOCOL = 3'h5;
  localparam [2:0] REG_SUMMARY  = 3'h6;

  localparam IS_SOCKET_ZERO = (SOCKET_INDEX == 0);

  function [2:0] reg_decode;
    input [11:0] addr;
    begin
      case ({addr[11:2], 2'b00})
        `SSEF_OFS_COMMAND:     reg_decode = REG_COMMAND;
        `SSEF_OFS_EVENT_MASK:  reg_decode = REG_MASK;
        `SSEF_OFS_STATE:       reg_decode = REG_STATE;
        `SSEF_OFS_EVENT_FLAGS: reg_decode = REG_FLAGS;
        `SSEF_OFS_PROTOCOL:    reg_decode = REG_PROTOCOL;
        `SSEF_OFS_SUMMARY:     reg_decode = REG_SUMMARY;
        default:               reg_decode = REG_NONE;
      endcase
    end
  endfunction

  // State entered by an open command; released when the mode is unusable
  function [7:0] open_state;
    input [3:0] proto;
    begin
      case (proto)
        `SSEF_PROTO_TCP:     open_state = `SSEF_ST_INITIALISED;
        `SSEF_PROTO_UDP:     open_state = `SSEF_ST_DATAGRAM;
        `SSEF_PROTO_IPRAW:   open_state = `SSEF_ST_RAW_NETWORK;
        `SSEF_PROTO_MACRAW:  open_state = IS_SOCKET_ZERO ? `SSEF_ST_RAW_LINK
                                                         : `SSEF_ST_RELEASED;
        `SSEF_PROTO_SESSION: open_state = IS_SOCKET_ZERO ? `SSEF_ST_SESSION_TUN
                                                         : `SSEF_ST_RELEASED;
        default:             open_state = `SSEF_ST_RELEASED;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  reg  [7:0]  event_mask;
  reg  [7:0]  event_flags;
  reg  [7:0]  socket_state;
  reg  [3:0]  protocol_field;
  reg         global_mask;
  reg         summary;
  reg         aw_held;
  reg         w_held;
  reg  [11:0] aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  wire        aw_take = s_axi_awvalid & s_axi_awready;
  wire        w_take  = s_axi_wvalid & s_axi_wready;
  wire        wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire        ar_take = s_axi_arvalid & s_axi_arready;
  wire [2:0]  wr_reg  = reg_decode(aw_addr);
  wire        wr_lo   = wr_fire & w_strb[0];
  wire [7:0]  cmd     = wr_lo & (wr_reg == REG_COMMAND) ? w_data[7:0] : 8'h00;
  wire        next_aw_held = wr_fire ? 1'b0 : (aw_held | aw_take);
  wire        next_w_held  = wr_fire ? 1'b0 : (w_held | w_take);
  wire        next_rvalid  = ar_take | (s_axi_rvalid & ~s_axi_rready);

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SSEF_RESP_OKAY;
    end else begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      s_axi_awready <= ~next_aw_held;
      s_axi_wready  <= ~next_w_held;
      if (aw_take) begin
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_reg == REG_NONE) ? `SSEF_RESP_SLVERR : `SSEF_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SSEF_RESP_OKAY;
    end else begin
      s_axi_rvalid  <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
      if (ar_take) begin
        s_axi_rresp <= `SSEF_RESP_OKAY;
        case (reg_decode(s_axi_araddr))
          REG_MASK:     s_axi_rdata <= {24'h000000, event_mask};
          REG_STATE:    s_axi_rdata <= {24'h000000, socket_state};
          REG_FLAGS:    s_axi_rdata <= {24'h000000, event_flags};
          REG_PROTOCOL: s_axi_rdata <= {28'h0000000, protocol_field};
          REG_SUMMARY:  s_axi_rdata <= {30'h0, global_mask, summary};
          REG_COMMAND:  s_axi_rdata <= 32'h0000_0000;
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SSEF_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      event_mask     <= `SSEF_RST_EVENT_MASK;
      protocol_field <= `SSEF_RST_PROTOCOL;
      global_mask    <= `SSEF_RST_GLOBAL_MASK;
    end else begin
      if (wr_lo && wr_reg == REG_MASK) begin
        event_mask <= w_data[7:0];
      end
      if (wr_lo && wr_reg == REG_PROTOCOL) begin
        protocol_field <= w_data[3:0];
      end
      if (wr_lo && wr_reg == REG_SUMMARY) begin
        global_mask <= w_data[`SSEF_BIT_GLOBAL_MASK];
      end
    end
  end

  // --------------------------------------------------------------------------
  // Event flags, summary and interrupt
  // --------------------------------------------------------------------------
  reg [7:0] raw_events;
  reg [7:0] clear_bits;
  reg [7:0] next_flags;

  always @* begin
    raw_events = 8'h00;
    raw_events[`SSEF_BIT_SESSION_OPTION] = ev_session_option;
    raw_events[`SSEF_BIT_SESSION_FAIL]   = ev_session_fail;
    raw_events[`SSEF_BIT_SESSION_NEXT]   = ev_session_next;
    raw_events[`SSEF_BIT_SEND_DONE]      = ev_send_done;
    raw_events[`SSEF_BIT_TIMEOUT]        = ev_arp_timeout | ev_tcp_timeout;
    raw_events[`SSEF_BIT_RX]             = ev_rx_packet;
    raw_events[`SSEF_BIT_PEER_PEER_DISCONNECT_FLAG]    = ev_peer_fin;
    raw_events[`SSEF_BIT_CONNECTED]      = ev_connected;
    clear_bits = (wr_lo && wr_reg == REG_FLAGS) ? w_data[7:0] : 8'h00;
    next_flags = (event_flags & ~clear_bits) | (raw_events & event_mask);
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      event_flags <= `SSEF_RST_EVENT_FLAGS;
      summary     <= 1'b0;
      irq_n       <= 1'b1;
    end else begin
      event_flags <= next_flags;
      summary     <= |next_flags;
      irq_n       <= ~((|next_flags) & global_mask);
    end
  end

  // --------------------------------------------------------------------------
  // Socket state machine and engine requests
  // --------------------------------------------------------------------------
  reg [7:0] next_state;
  wire      can_transfer = (socket_state == `SSEF_ST_CONNECTED)
                         | (socket_state == `SSEF_ST_HALF_CLOSED)
                         | (socket_state == `SSEF_ST_DATAGRAM)
                         | (socket_state == `SSEF_ST_RAW_NETWORK)
                         | (socket_state == `SSEF_ST_RAW_LINK);

  always @* begin
    next_state = socket_state;
    if (cmd == `SSEF_CMD_PEER_DISCONNECT_FLAG || cmd == `SSEF_CMD_CLOSE ||
        ev_arp_timeout || ev_tcp_timeout) begin
      next_state = `SSEF_ST_RELEASED;
    end else begin
      case (socket_state)
        `SSEF_ST_RELEASED: begin
          if (cmd == `SSEF_CMD_OPEN) begin
            next_state = open_state(protocol_field);
          end
        end
        `SSEF_ST_INITIALISED: begin
          if (cmd == `SSEF_CMD_LISTEN) begin
            next_state = `SSEF_ST_LISTENING;
          end else if (ev_connected) begin
            next_state = `SSEF_ST_CONNECTED;
          end
        end
        `SSEF_ST_LISTENING: begin
          if (ev_connected) begin
            next_state = `SSEF_ST_CONNECTED;
          end
        end
        `SSEF_ST_CONNECTED: begin
          if (ev_peer_fin) begin
            next_state = `SSEF_ST_HALF_CLOSED;
          end
        end
        default: begin
          next_state = socket_state;
        end
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      socket_state   <= `SSEF_RST_STATE;
      send_req       <= 1'b0;
      rx_flag_req       <= 1'b0;
      connect_req    <= 1'b0;
      disconnect_req <= 1'b0;
    end else begin
      socket_state   <= next_state;
      send_req       <= (cmd == `SSEF_CMD_SEND) & can_transfer;
      rx_flag_req       <= (cmd == `SSEF_CMD_RX_FLAG) & can_transfer;
      connect_req    <= (cmd == `SSEF_CMD_CONNECT)
                      & (socket_state == `SSEF_ST_INITIALISED);
      disconnect_req <= (cmd == `SSEF_CMD_PEER_DISCONNECT_FLAG)
                      & ((socket_state == `SSEF_ST_CONNECTED)
                       | (socket_state == `SSEF_ST_HALF_CLOSED));
    end
  end

endmodule

/* testbench/ssef_socket_flags_properties.sv */
// Port assertions for the socket flag block.
// Assumes one clock and a synchronous active-low reset.
`include "ssef_map.vh"
module ssef_socket_flags_properties (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        send_req
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [11:0] rd_addr;
  always @(posedge aclk) begin
    if (s_axi_arvalid && s_axi_arready) begin
      rd_addr <= s_axi_araddr;
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  upper_zero_a: assert property (
    s_axi_rvalid && rd_addr == `SSEF_OFS_STATE |-> s_axi_rdata[31:8] == 24'h0)
    else $error("state upper byte set");
  send_pulse_a: assert property (send_req |=> !send_req)
    else $error("send request too long");
  write_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write response late");
  aw_block_a: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("second write address taken");
  w_block_a: assert property (
    s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("second write data taken");
  read_resp_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  unmapped_rd_a: assert property (
    s_axi_arvalid && s_axi_arready && (s_axi_araddr[11:2] < 10'h080 ||
    s_axi_araddr[11:2] > 10'h085)
    |=> s_axi_rresp == `SSEF_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
endmodule

/* testbench/ssef_host_model.sv */
// Host processor model: an AXI4-Lite master for the register port.
// Assumes the bench calls wr and rd one at a time.
module ssef_host_model (
  input  wire        aclk,
  output reg  [11:0] awaddr  = 12'h0,
  output reg         awvalid = 1'b0,
  input  wire        awready,
  output reg  [31:0] wdata   = 32'h0,
  output reg  [3:0]  wstrb   = 4'hf,
  output reg         wvalid  = 1'b0,
  input  wire        wready,
  input  wire [1:0]  bresp,
  input  wire        bvalid,
  output reg         bready  = 1'b0,
  output reg  [11:0] araddr  = 12'h0,
  output reg         arvalid = 1'b0,
  input  wire        arready,
  input  wire [31:0] rdata,
  input  wire [1:0]  rresp,
  input  wire        rvalid,
  output reg         rready  = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released lines show the inverse, never a stale value
  task wr(input [11:0] a, input [31:0] d, output [1:0] r);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (awvalid && awready) begin
          awvalid <= 1'b0;
          awaddr <= ~a;
        end
        if (wvalid && wready) begin
          wvalid <= 1'b0;
          wdata <= ~d;
        end
      end while (!(bvalid && bready));
      r = bresp;
      bready <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, output [31:0] d, output [1:0] r);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (arvalid && arready) begin
          arvalid <= 1'b0;
          araddr <= ~a;
        end
      end while (!(rvalid && rready));
      d = rdata;
      r = rresp;
      rready <= 1'b0;
    end
  endtask
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the socket flag block with a host model.
// Assumes the design and its map header are on the include path.
`include "ssef_map.vh"
`define CHK(g, e) begin compares = compares + 1; if ((g) !== (e)) begin \
  n_fail = n_fail + 1; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [8:0]  ev = 9'h0;
  reg  [31:0] d, m;
  reg  [1:0]  r;
  reg  [3:0]  fb;
  integer     n_fail = 0, compares = 0, seed = 32'he557, cyc = 0, i, es = 0;
  integer     n_send = 0, n_rx_flag = 0, n_conn = 0, n_disc = 0;
  wire [11:0] awaddr, araddr;
  wire [31:0] wdata, rdata;
  wire [3:0]  wstrb;
  wire [1:0]  bresp, rresp;
  wire        awvalid, awready, wvalid, wready, bvalid, bready;
  wire        arvalid, arready, rvalid, rready;
  wire        send_req, rx_flag_req, connect_req, disconnect_req, irq_n;
  initial forever #2 aclk = ~aclk;
  ssef_host_model u_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  ssef_socket_flags #(.SOCKET_INDEX(0)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ev_connected(ev[0]), .ev_peer_fin(ev[1]), .ev_rx_packet(ev[2]), .ev_arp_timeout(ev[3]),
    .ev_send_done(ev[4]), .ev_session_next(ev[5]), .ev_session_fail(ev[6]),
    .ev_session_option(ev[7]), .ev_tcp_timeout(ev[8]), .send_req(send_req),
    .rx_flag_req(rx_flag_req), .connect_req(connect_req), .disconnect_req(disconnect_req),
    .irq_n(irq_n));
  function [7:0] open_state(input [3:0] p);
    case (p)
      `SSEF_PROTO_TCP: open_state = `SSEF_ST_INITIALISED;
      `SSEF_PROTO_UDP: open_state = `SSEF_ST_DATAGRAM;
      `SSEF_PROTO_IPRAW: open_state = `SSEF_ST_RAW_NETWORK;
      `SSEF_PROTO_MACRAW: open_state = `SSEF_ST_RAW_LINK;
      `SSEF_PROTO_SESSION: open_state = `SSEF_ST_SESSION_TUN;
      default: open_state = `SSEF_ST_RELEASED;
    endcase
  endfunction
  function [31:0] exp_flags(input [31:0] mk, input [3:0] b);
    exp_flags = mk & (32'h1 << b);
  endfunction
  task final_report;
    begin
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk_rd(input [11:0] a, input [31:0] e);
    begin
      u_host.rd(a, d, r);
      `CHK(d, e)
    end
  endtask
  task cmd(input [7:0] c);
    u_host.wr(`SSEF_OFS_COMMAND, {24'h0, c}, r);
  endtask
  task pulse(input integer k);
    begin
      @(posedge aclk);
      ev[k] <= 1'b1;
      @(posedge aclk);
      ev <= 9'h0;
      #1;
    end
  endtask
  always @(posedge aclk) begin
    cyc = cyc + 1;
    n_send = n_send + send_req;
    n_rx_flag = n_rx_flag + rx_flag_req;
    n_conn = n_conn + connect_req;
    n_disc = n_disc + disconnect_req;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      final_report;
    end
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rd(`SSEF_OFS_EVENT_MASK, 32'hff);
    chk_rd(`SSEF_OFS_EVENT_FLAGS, 32'h0);
    chk_rd(`SSEF_OFS_STATE, 32'h0);
    chk_rd(`SSEF_OFS_SUMMARY, 32'h0);
    chk_rd(12'h300, 32'h0);
    `CHK(r, `SSEF_RESP_SLVERR)
    u_host.wr(12'h0f0, $random(seed), r);
    `CHK(r, `SSEF_RESP_SLVERR)
    u_host.wr(`SSEF_OFS_STATE, 32'h17, r);
    chk_rd(`SSEF_OFS_STATE, 32'h0);
    u_host.wr(`SSEF_OFS_SUMMARY, 32'h2, r);
    for (i = 0; i < 18; i = i + 1) begin
      fb = (i % 9 == 8) ? 4'd3 : i % 9;
      m = $random(seed);
      m = (i < 9) ? (m | (32'h1 << fb)) : (m & ~(32'h1 << fb));
      u_host.wr(`SSEF_OFS_EVENT_MASK, m, r);
      pulse(i % 9);
      `CHK(irq_n, exp_flags(m, fb) == 0)
      chk_rd(`SSEF_OFS_SUMMARY, {30'h0, 1'b1, exp_flags(m, fb) != 32'h0});
      chk_rd(`SSEF_OFS_EVENT_FLAGS, exp_flags(m, fb));
      u_host.wr(`SSEF_OFS_EVENT_FLAGS, 32'hff, r);
      chk_rd(`SSEF_OFS_EVENT_FLAGS, 32'h0);
      `CHK(irq_n, 1'b1)
      chk_rd(`SSEF_OFS_SUMMARY, 32'h2);
    end
    for (i = 0; i < 7; i = i + 1) begin
      u_host.wr(`SSEF_OFS_PROTOCOL, i, r);
      cmd(`SSEF_CMD_OPEN);
      chk_rd(`SSEF_OFS_STATE, open_state(i));
      cmd(`SSEF_CMD_SEND);
      es = es + (open_state(i) inside {8'h22, 8'h32, 8'h42});
      cmd(`SSEF_CMD_CLOSE);
      chk_rd(`SSEF_OFS_STATE, 32'h0);
    end
    u_host.wr(`SSEF_OFS_PROTOCOL, `SSEF_PROTO_TCP, r);
    cmd(`SSEF_CMD_OPEN);
    cmd(`SSEF_CMD_SEND);
    cmd(`SSEF_CMD_LISTEN);
    chk_rd(`SSEF_OFS_STATE, 32'h14);
    pulse(0);
    chk_rd(`SSEF_OFS_STATE, 32'h17);
    cmd(`SSEF_CMD_SEND);
    cmd(`SSEF_CMD_RX_FLAG);
    pulse(1);
    chk_rd(`SSEF_OFS_STATE, 32'h1c);
    cmd(`SSEF_CMD_RX_FLAG);
    cmd(`SSEF_CMD_PEER_DISCONNECT_FLAG);
    chk_rd(`SSEF_OFS_STATE, 32'h0);
    `CHK(n_send, es + 1)
    `CHK(n_rx_flag, 2)
    `CHK(n_disc, 1)
    cmd(`SSEF_CMD_OPEN);
    cmd(`SSEF_CMD_CONNECT);
    @(posedge aclk);
    `CHK(n_conn, 1)
    pulse(0);
    chk_rd(`SSEF_OFS_STATE, 32'h17);
    pulse(8);
    chk_rd(`SSEF_OFS_STATE, 32'h0);
    u_host.wr(`SSEF_OFS_EVENT_MASK, 32'hff, r);
    cmd(`SSEF_CMD_OPEN);
    cmd(`SSEF_CMD_LISTEN);
    u_host.wr(`SSEF_OFS_EVENT_FLAGS, 32'hff, r);
    pulse(8);
    chk_rd(`SSEF_OFS_STATE, 32'h0);
    chk_rd(`SSEF_OFS_EVENT_FLAGS, 32'h8);
    final_report;
  end
endmodule
bind ssef_socket_flags ssef_socket_flags_properties u_props (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .send_req(send_req));
